// *** tx_coding_pkg.sv ***
/*
 Constants, state encoding and the 4B/5B data table for the 100 Mb/s
 transmit coding path. Assumes a 25 MHz nibble clock and a 125 MHz
 symbol clock, so one code-group is consumed per nibble period.
*/
`default_nettype none

package tx_coding_pkg;

    localparam int GROUP_W  = 5;
    localparam int NIB_W    = 4;
    localparam int BYTE_W   = 8;
    localparam int ADDR_W   = 5;
    localparam int LFSR_W   = 11;

    // Line codes
    localparam logic [GROUP_W-1:0] CG_IDLE = 5'h1F;
    localparam logic [GROUP_W-1:0] CG_J    = 5'h18;
    localparam logic [GROUP_W-1:0] CG_K    = 5'h11;
    localparam logic [GROUP_W-1:0] CG_T    = 5'h0D;
    localparam logic [GROUP_W-1:0] CG_R    = 5'h07;
    localparam logic [GROUP_W-1:0] CG_HALT = 5'h04;

    // Scrambler taps for x^11 + x^9 + 1
    localparam int TAP_HI = 10;
    localparam int TAP_LO = 8;
    localparam logic [LFSR_W-1:0] LFSR_RST = 11'h7FF;

    // Clock rates and derived symbol count per nibble period
    localparam int CLK_MHZ     = 25;
    localparam int SYM_MHZ     = 125;
    localparam int SYM_PER_NIB = SYM_MHZ / CLK_MHZ;
    localparam logic [2:0] BIT_LAST = 3'(SYM_PER_NIB - 1);

    // Link-clock cycles the strap synchroniser needs before the seed is used
    localparam logic [1:0] SEED_WAIT = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_K    = 2'b01,
        ST_DATA = 2'b10,
        ST_R    = 2'b11
    } enc_state_t;

    function automatic logic [GROUP_W-1:0] enc_4b5b(input logic [NIB_W-1:0] nib);
        logic [GROUP_W-1:0] cg;
        cg = CG_IDLE;
        case (nib)
            4'h0: cg = 5'h1E;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0A;
            4'h5: cg = 5'h0B;
            4'h6: cg = 5'h0E;
            4'h7: cg = 5'h0F;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'hA: cg = 5'h16;
            4'hB: cg = 5'h17;
            4'hC: cg = 5'h1A;
            4'hD: cg = 5'h1B;
            4'hE: cg = 5'h1C;
            4'hF: cg = 5'h1D;
            default: cg = CG_IDLE;
        endcase
        return cg;
    endfunction

endpackage

`default_nettype wire

// *** fast_ethernet_tx_coding_path.sv ***
/*
 Transmit coding path: MII nibbles to 4B/5B code-groups with J/K, T/R,
 HALT and IDLE insertion, a gray-pointer crossing into the symbol clock,
 serialisation and an 11-bit self-running scrambler seeded from straps.
 Byte-wide mode passes data to the gigabit path instead.
 Assumes MAC transmit signals are synchronous to clk and that sym_clk
 runs continuously at five times the clk rate.
*/
// Notes on behaviour
// R1 - Every MAC nibble becomes its 5-bit code-group before serialisation.
// R2 - First two preamble nibbles are replaced by J then K.
// R3 - Drop of transmit enable emits T then R.
// R4 - IDLE code-groups run continuously until transmit enable returns.
// R5 - Code-groups leave as a serial stream at the symbol rate.
// R6 - Scrambler is a free-running closed-loop 11-bit LFSR.
// R7 - Each serial bit is XORed with the scrambler output bit.
// R8 - Scrambler seed comes from the strapped 5-bit port address.
// R9 - Sequencing follows the standard 100BASE-X transmit state machine.
// R10 - MAC side takes byte or nibble data; nibble mode uses bits 3:0.
// R11 - Byte mode uses an independent 8-bit path synchronous to its clock.
// R12 - Carrier-present and collision status are driven toward the MAC.
// R13 - Transmit error during a frame sends HALT but keeps delimiters.
// R14 - Inter-packet IDLE code-group is 11111.
// R15 - Feedback is x^11 + x^9 + 1; an all-zero seed is never loaded.
// R16 - Data nibbles map through the standard 4B/5B data table.
`timescale 1ns/1ns
`default_nettype none

module fast_ethernet_tx_coding_path
    import tx_coding_pkg::*;
#(
    parameter int FIFO_AW = 2
)
(
    // MAC-side clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,

    // Symbol clock
    input  wire logic              sym_clk,

    // MAC transmit interface
    input  wire logic              tx_en,
    input  wire logic              tx_er,
    input  wire logic [BYTE_W-1:0] txd,

    // Configuration pins
    input  wire logic              gmii_mode,
    input  wire logic              full_duplex,
    input  wire logic [ADDR_W-1:0] phy_address_straps,

    // Media status
    input  wire logic              rx_carrier,
    output logic                   crs,
    output logic                   col,

    // Gigabit transmit path
    output logic [BYTE_W-1:0]      gbe_txd,
    output logic                   gbe_tx_en,
    output logic                   gbe_tx_er,

    // Serial stream toward the line encoder, and the sticky queue overrun flag
    output logic                   nrz_bit,
    output logic                   scr_bit,
    output logic                   tx_overrun
);

    localparam int PW = FIFO_AW + 1;
    localparam int DEPTH = 1 << FIFO_AW;

    // Pin synchronisers, clk domain
    logic              mode_s1_r;
    logic              mode_s2_r;
    logic              fdx_s1_r;
    logic              fdx_s2_r;
    logic              car_s1_r;
    logic              car_s2_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
            fdx_s1_r  <= 1'b0;
            fdx_s2_r  <= 1'b0;
            car_s1_r  <= 1'b0;
            car_s2_r  <= 1'b0;
        end else begin
            mode_s1_r <= gmii_mode;
            mode_s2_r <= mode_s1_r;
            fdx_s1_r  <= full_duplex;
            fdx_s2_r  <= fdx_s1_r;
            car_s1_r  <= rx_carrier;
            car_s2_r  <= car_s1_r;
        end
    end

    // Code-group encoder
    enc_state_t         state_r;
    enc_state_t         state_nxt;
    logic [GROUP_W-1:0] cg_nxt;

    always_comb begin
        state_nxt = state_r;
        cg_nxt    = CG_IDLE;                                          // [R14]
        case (state_r)
            ST_IDLE: begin
                if (tx_en && !mode_s2_r) begin
                    cg_nxt    = CG_J;                                 // [R2]
                    state_nxt = ST_K;
                end else begin
                    cg_nxt    = CG_IDLE;                              // [R4]
                end
            end
            ST_K: begin
                cg_nxt    = CG_K;                                     // [R2]
                state_nxt = ST_DATA;
            end
            ST_DATA: begin
                if (tx_en) begin
                    // Nibble mode reads only the low data bits
                    cg_nxt = tx_er ? CG_HALT : enc_4b5b(txd[NIB_W-1:0]); // [R1] [R13] [R16] [R10]
                end else begin
                    cg_nxt    = CG_T;                                 // [R3]
                    state_nxt = ST_R;
                end
            end
            ST_R: begin
                cg_nxt    = CG_R;                                     // [R3]
                state_nxt = ST_IDLE;
            end
            default: begin
                cg_nxt    = CG_IDLE;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;                                     // [R9]
        end
    end

    // Crossing into the symbol clock: small gray-pointer queue
    logic [GROUP_W-1:0] mem [DEPTH];
    logic [PW-1:0]      wbin_r;
    logic [PW-1:0]      wgray_r;
    logic [PW-1:0]      rgray_s1_r;
    logic [PW-1:0]      rgray_s2_r;
    logic [PW-1:0]      rgray_r;
    logic [PW-1:0]      wbin_inc;
    logic               full;
    logic               wr_go;

    assign wbin_inc = wbin_r + PW'(1);
    assign full     = (wgray_r == {~rgray_s2_r[PW-1:PW-2], rgray_s2_r[PW-3:0]});
    // Idle stream is pushed too, so the line never starves mid-frame
    assign wr_go    = !mode_s2_r && !full;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wbin_r  <= '0;
            wgray_r <= '0;
        end else if (wr_go) begin
            wbin_r  <= wbin_inc;
            wgray_r <= wbin_inc ^ (wbin_inc >> 1);
        end
    end

    always_ff @(posedge clk) begin
        if (wr_go) begin
            mem[wbin_r[FIFO_AW-1:0]] <= cg_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rgray_s1_r <= '0;
            rgray_s2_r <= '0;
        end else begin
            rgray_s1_r <= rgray_r;
            rgray_s2_r <= rgray_s1_r;
        end
    end

    // Sticky: a slow symbol clock loses code-groups
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_overrun <= 1'b0;
        end else if (!mode_s2_r && full) begin
            tx_overrun <= 1'b1;
        end
    end

    // Media status toward the MAC
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            crs <= 1'b0;
            col <= 1'b0;
        end else begin
            crs <= tx_en || car_s2_r;                                 // [R12]
            col <= tx_en && car_s2_r && !fdx_s2_r;                    // [R12]
        end
    end

    // Byte-wide path, registered on the transmit clock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gbe_txd   <= '0;
            gbe_tx_en <= 1'b0;
            gbe_tx_er <= 1'b0;
        end else if (mode_s2_r) begin
            gbe_txd   <= txd;                                         // [R10] [R11]
            gbe_tx_en <= tx_en;
            gbe_tx_er <= tx_er;
        end else begin
            gbe_txd   <= '0;
            gbe_tx_en <= 1'b0;
            gbe_tx_er <= 1'b0;
        end
    end

    // Symbol clock domain: reset and pin synchronisers
    logic              lrst_s1_r;
    logic              lrst_s2_r;
    logic [ADDR_W-1:0] adr_s1_r;
    logic [ADDR_W-1:0] adr_s2_r;
    logic [PW-1:0]     wgray_s1_r;
    logic [PW-1:0]     wgray_s2_r;

    always_ff @(posedge sym_clk) begin
        lrst_s1_r <= rst_b;
        lrst_s2_r <= lrst_s1_r;
        adr_s1_r  <= phy_address_straps;
        adr_s2_r  <= adr_s1_r;
    end

    always_ff @(posedge sym_clk) begin
        if (!lrst_s2_r) begin
            wgray_s1_r <= '0;
            wgray_s2_r <= '0;
        end else begin
            wgray_s1_r <= wgray_r;
            wgray_s2_r <= wgray_s1_r;
        end
    end

    // Read side and serialiser
    logic [PW-1:0]      rbin_r;
    logic [PW-1:0]      rbin_inc;
    logic               empty;
    logic [GROUP_W-1:0] sh_r;
    logic [2:0]         bitcnt_r;
    logic               rd_go;

    assign rbin_inc = rbin_r + PW'(1);
    assign empty    = (rgray_r == wgray_s2_r);
    assign rd_go    = (bitcnt_r == BIT_LAST) && !empty;

    always_ff @(posedge sym_clk) begin
        if (!lrst_s2_r) begin
            rbin_r  <= '0;
            rgray_r <= '0;
        end else if (rd_go) begin
            rbin_r  <= rbin_inc;
            rgray_r <= rbin_inc ^ (rbin_inc >> 1);
        end
    end

    // Most significant code bit goes first; an empty queue sends IDLE
    always_ff @(posedge sym_clk) begin
        if (!lrst_s2_r) begin
            sh_r     <= CG_IDLE;
            bitcnt_r <= '0;
        end else if (bitcnt_r == BIT_LAST) begin
            sh_r     <= empty ? CG_IDLE : mem[rbin_r[FIFO_AW-1:0]];  // [R4] [R5]
            bitcnt_r <= '0;
        end else begin
            sh_r     <= {sh_r[GROUP_W-2:0], 1'b0};                    // [R5]
            bitcnt_r <= bitcnt_r + 3'h1;
        end
    end

    // Scrambler
    logic [LFSR_W-1:0] lfsr_r;
    logic [1:0]        seed_cnt_r;
    logic              scr_fb;

    assign scr_fb = lfsr_r[TAP_HI] ^ lfsr_r[TAP_LO];                  // [R15]

    // Leading one keeps the seed nonzero for every address
    always_ff @(posedge sym_clk) begin
        if (!lrst_s2_r) begin
            lfsr_r     <= LFSR_RST;
            seed_cnt_r <= '0;
        end else if (seed_cnt_r != SEED_WAIT) begin
            lfsr_r     <= {1'b1, adr_s2_r, ~adr_s2_r};                // [R8] [R15]
            seed_cnt_r <= seed_cnt_r + 2'h1;
        end else begin
            lfsr_r     <= {lfsr_r[LFSR_W-2:0], scr_fb};               // [R6]
        end
    end

    always_ff @(posedge sym_clk) begin
        if (!lrst_s2_r) begin
            nrz_bit <= 1'b0;
            scr_bit <= 1'b0;
        end else begin
            nrz_bit <= sh_r[GROUP_W-1];
            scr_bit <= sh_r[GROUP_W-1] ^ scr_fb;                      // [R7]
        end
    end

endmodule

`default_nettype wire

// *** tx_coding_sva.sv ***
/*
 Port checker for the transmit coding path: media status, byte path and
 scrambler keystream. Assumes the top module is bound below.
*/
`timescale 1ns/1ns
`default_nettype none

module tx_coding_sva
    import tx_coding_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              sym_clk,
    input wire logic              tx_en,
    input wire logic              tx_er,
    input wire logic [BYTE_W-1:0] txd,
    input wire logic              gmii_mode,
    input wire logic              full_duplex,
    input wire logic              rx_carrier,
    input wire logic              crs,
    input wire logic              col,
    input wire logic [BYTE_W-1:0] gbe_txd,
    input wire logic              gbe_tx_en,
    input wire logic              gbe_tx_er,
    input wire logic              nrz_bit,
    input wire logic              scr_bit
);
    logic [2:0]  up_r;
    logic [4:0]  sym_up_r;
    logic [10:0] ks_r;

    // Synchronisers still carry reset-time values just after release
    always_ff @(posedge clk) begin
        if (!rst_b)
            up_r <= 3'h0;
        else if (up_r != 3'h7)
            up_r <= up_r + 3'h1;
    end

    always_ff @(posedge sym_clk) begin
        if (!rst_b)
            sym_up_r <= 5'h00;
        else if (sym_up_r != 5'h1F)
            sym_up_r <= sym_up_r + 5'h01;
    end

    always_ff @(posedge sym_clk) begin
        ks_r <= {ks_r[9:0], scr_bit ^ nrz_bit};
    end

    a_crs_own_tx: assert property (@(posedge clk) disable iff (!rst_b)
        (up_r == 3'h7 && !rx_carrier)[*4] |=> crs == $past(tx_en)) else $error("crs not own transmit");
    a_crs_carrier: assert property (@(posedge clk) disable iff (!rst_b)
        (up_r == 3'h7 && rx_carrier)[*4] |=> crs) else $error("crs missing with carrier");
    a_col_half_dup: assert property (@(posedge clk) disable iff (!rst_b)
        (up_r == 3'h7 && rx_carrier && !full_duplex)[*4] |=> col == $past(tx_en)) else $error("col wrong");
    a_col_full_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (up_r == 3'h7 && full_duplex)[*4] |=> !col) else $error("col in full duplex");
    a_byte_path_copy: assert property (@(posedge clk) disable iff (!rst_b)
        (up_r == 3'h7 && gmii_mode)[*4] |=> gbe_txd == $past(txd) && gbe_tx_en == $past(tx_en)
        && gbe_tx_er == $past(tx_er)) else $error("byte path not copied");
    a_nibble_path_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (up_r == 3'h7 && !gmii_mode)[*4] |=> gbe_txd == 8'h00 && !gbe_tx_en && !gbe_tx_er)
        else $error("byte path active in nibble mode");
    a_scr_recurrence: assert property (@(posedge sym_clk) disable iff (!rst_b)
        sym_up_r == 5'h1F |-> (scr_bit ^ nrz_bit) == (ks_r[8] ^ ks_r[10])) else $error("keystream off");
    a_scr_nonzero: assert property (@(posedge sym_clk) disable iff (!rst_b)
        sym_up_r == 5'h1F |-> ks_r != 11'h000) else $error("scrambler stuck at zero");

    c_collision: cover property (@(posedge clk) disable iff (!rst_b) col);
    c_byte_frame: cover property (@(posedge clk) disable iff (!rst_b) gmii_mode && gbe_tx_en);
    c_error_frame: cover property (@(posedge clk) disable iff (!rst_b) tx_en && tx_er);
endmodule

bind fast_ethernet_tx_coding_path tx_coding_sva chk (.clk, .rst_b, .sym_clk, .tx_en, .tx_er, .txd,
    .gmii_mode, .full_duplex, .rx_carrier, .crs, .col, .gbe_txd, .gbe_tx_en, .gbe_tx_er, .nrz_bit, .scr_bit);

`default_nettype wire

// *** mac_model.sv ***
/*
 MAC model: sends a frame of two preamble beats and len data beats.
 Assumes go is a one-cycle request while busy is low.
*/
`timescale 1ns/1ns
`default_nettype none

module mac_model
    import tx_coding_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              go,
    input  wire logic [BYTE_W-1:0] beat,
    input  wire logic              err,
    input  wire logic [7:0]        len,
    output logic                   tx_en,
    output logic                   tx_er,
    output logic [BYTE_W-1:0]      txd,
    output logic                   busy
);
    logic [7:0]        cnt_r = 8'h00;
    logic              en_r  = 1'b0;
    logic              er_r  = 1'b0;
    logic [BYTE_W-1:0] dat_r = 8'h00;

    // Everything changes only on clk
    always @(posedge clk) begin
        if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
            en_r  <= 1'b1;
            er_r  <= err && (cnt_r <= len);
            dat_r <= (cnt_r > len) ? 8'h55 : beat;
        end else begin
            en_r  <= 1'b0;
            er_r  <= 1'b0;
            // Released data never repeats its last value
            dat_r <= ~dat_r;
        end
        if (go && cnt_r == 8'h00)
            cnt_r <= len + 8'h02;
    end

    assign tx_en = en_r;
    assign tx_er = er_r;
    assign txd   = dat_r;
    assign busy  = (cnt_r != 8'h00) || en_r;
endmodule

`default_nettype wire

// *** fast_ethernet_tx_coding_path_tb_top.sv ***
/*
 Self-checking bench for the transmit coding path with a MAC model.
 Assumes the checker is bound to the design by its own file.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end

module fast_ethernet_tx_coding_path_tb_top
    import tx_coding_pkg::*;
;
    logic              clk, sym_clk, rst_b, go, err, gmii_mode, full_duplex, rx_carrier;
    logic              tx_en, tx_er, crs, col, gbe_tx_en, gbe_tx_er, nrz_bit, scr_bit, busy, tx_overrun;
    logic [BYTE_W-1:0] beat, txd, gbe_txd;
    logic [7:0]        len;
    logic [ADDR_W-1:0] phy_address_straps;
    int                failures = 0;
    int                check_count = 0;
    logic [4:0]        code_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                         5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        sym_clk = 1'b0;
        #7;
        forever #80 sym_clk = ~sym_clk;
    end

    mac_model mac (.clk(clk), .go(go), .beat(beat), .err(err), .len(len),
                   .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .busy(busy));

    fast_ethernet_tx_coding_path #(.FIFO_AW(2)) DUT (.clk(clk), .rst_b(rst_b), .sym_clk(sym_clk),
        .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .gmii_mode(gmii_mode), .full_duplex(full_duplex),
        .phy_address_straps(phy_address_straps), .rx_carrier(rx_carrier), .crs(crs), .col(col),
        .gbe_txd(gbe_txd), .gbe_tx_en(gbe_tx_en), .gbe_tx_er(gbe_tx_er), .nrz_bit(nrz_bit),
        .scr_bit(scr_bit), .tx_overrun(tx_overrun));

    task automatic results;
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Held 12 cycles: the symbol domain needs three of its own edges
    task automatic reset_dut(input logic [4:0] strap);
        @(posedge sym_clk);
        @(posedge clk);
        phy_address_straps <= strap;
        rst_b <= 1'b0;
        repeat (11) @(posedge clk);
        #1;
        `CHK("overrun_rst", 1'b0, tx_overrun)
        `CHK("crs_rst", 1'b0, crs)
        @(posedge clk);
        rst_b <= 1'b1;
    endtask

    task automatic wait_done;
        for (int i = 0; i < 600 && busy; i++)
            @(posedge clk);
        if (busy) begin
            failures++;
            results();
        end
    endtask

    task automatic t_idle;
        logic [9:0] bits;
        repeat (120) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            @(negedge sym_clk);
            bits[i] = nrz_bit;
        end
        `CHK("idle", 10'h3FF, bits)
        // Bench symbol clock is far slower than the nibble rate, so the queue must have overrun
        `CHK("overrun", 1'b1, tx_overrun)
    endtask

    // Queue overruns in this bench, so only the steady mid-frame pattern is judged
    task automatic t_frame(input logic [7:0] val, input logic e, input logic [4:0] code);
        logic [9:0]  bits;
        logic [14:0] pat;
        logic        hit;
        @(posedge clk);
        go <= 1'b1;
        beat <= val;
        err <= e;
        len <= 8'd200;
        @(posedge clk);
        go <= 1'b0;
        repeat (120) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            @(negedge sym_clk);
            bits[9-i] = nrz_bit;
        end
        pat = {code, code, code};
        hit = 1'b0;
        for (int r = 0; r < 5; r++)
            hit = hit | (bits === pat[14-r -: 10]);
        `CHK("group", 1'b1, hit)
        wait_done();
        t_idle();
    endtask

    task automatic t_status;
        @(posedge clk);
        gmii_mode <= 1'b1;
        full_duplex <= 1'b0;
        rx_carrier <= 1'b1;
        repeat (4) @(posedge clk);
        go <= 1'b1;
        beat <= 8'h3C;
        err <= 1'b0;
        len <= 8'd20;
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        `CHK("gbe_txd", 8'h3C, gbe_txd)
        `CHK("col", 1'b1, col)
        `CHK("crs", 1'b1, crs)
        @(posedge clk);
        full_duplex <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("col_fd", 1'b0, col)
        wait_done();
        gmii_mode <= 1'b0;
        rx_carrier <= 1'b0;
    endtask

    task automatic grab_ks(output logic [31:0] v);
        repeat (8) @(posedge sym_clk);
        for (int i = 0; i < 32; i++) begin
            @(negedge sym_clk);
            v[i] = scr_bit ^ nrz_bit;
        end
    endtask

    task automatic t_seed;
        logic [31:0] a, b;
        reset_dut(5'h03);
        grab_ks(a);
        reset_dut(5'h1C);
        grab_ks(b);
        `CHK("seed_differs", 1'b1, a !== b)
    endtask

    initial begin
        rst_b <= 1'b0;
        go <= 1'b0;
        err <= 1'b0;
        beat <= 8'h00;
        len <= 8'h00;
        gmii_mode <= 1'b0;
        full_duplex <= 1'b0;
        rx_carrier <= 1'b0;
        phy_address_straps <= 5'h03;
        reset_dut(5'h03);
        t_idle();
        for (int n = 0; n < 16; n++)
            t_frame({4'hA, 4'(n)}, 1'b0, code_tab[n]);
        t_frame(8'hA7, 1'b1, CG_HALT);
        t_status();
        t_seed();
        results();
    end
endmodule

`default_nettype wire
